// ### sod_pkg.sv
// Package for the secondary opcode decoder: field positions, class codes,
// result encodings and the result carrier struct.
// Assumes a 32-bit instruction word with the usual field layout.
package sod_pkg;

  // Instruction field positions.
  localparam int SOD_OP_HI = 31;
  localparam int SOD_OP_LO = 26;
  localparam int SOD_RS_HI = 25;
  localparam int SOD_RS_LO = 21;
  localparam int SOD_RT_HI = 20;
  localparam int SOD_RT_LO = 16;
  localparam int SOD_FN_HI = 5;
  localparam int SOD_FN_LO = 0;

  // Primary opcodes that route to secondary tables (row, column packed).
  localparam logic [5:0] SOD_OP_REGFN = 6'h00;
  localparam logic [5:0] SOD_OP_REGISTER_IMMEDIATE_CLASS = 6'h01;
  localparam logic [5:0] SOD_OP_SYSTEM_COPROCESSOR_CLASS = 6'h10;
  localparam logic [5:0] SOD_OP_COP1 = 6'h11;
  localparam logic [5:0] SOD_OP_COP2 = 6'h12;
  localparam logic [5:0] SOD_OP_COP3 = 6'h13;
  localparam logic [5:0] SOD_OP_MAC = 6'h1C;

  // Privilege mode encodings.
  localparam logic [1:0] SOD_MODE_KERNEL = 2'h0;
  localparam logic [1:0] SOD_MODE_SUPER = 2'h1;
  localparam logic [1:0] SOD_MODE_USER = 2'h2;

  // Decoded operation classes.
  typedef enum logic [2:0] {
    SOD_CLS_NONE,
    SOD_CLS_REGFN,
    SOD_CLS_REGISTER_IMMEDIATE_CLASS,
    SOD_CLS_COPOP,
    SOD_CLS_COPBR,
    SOD_CLS_SYSCOP,
    SOD_CLS_MAC
  } sod_class_e;

  // Mode inputs supplied by the pipeline.
  typedef struct packed {
    logic [1:0] privMode;
    logic addr64En;
    logic [3:0] copUsable;
  } sod_mode_s;

  // Decode result: class, 6-bit table slot and exception requests.
  typedef struct packed {
    sod_class_e opClass;
    logic [5:0] slot;
    logic valid;
    logic isNop;
    logic resvExc;
    logic copUnusableExc;
    logic [1:0] copNum;
  } sod_result_s;

endpackage

// ### sod_result_reg.sv
// Holding register for the decode result, loaded on an issue strobe.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module sod_result_reg (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input sod_pkg::sod_result_s resultNxt,
  output sod_pkg::sod_result_s result_r
);
  import sod_pkg::*;

  // Capture the combinational result when an instruction is issued.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_r <= '0;
    end else if (load) begin
      result_r <= resultNxt;
    end
  end
endmodule

// ### sod_decoder.sv
// Secondary opcode decoder: classifies the secondary fields of an
// instruction word and raises reserved and coprocessor exceptions.
// Assumes the fetch stage supplies the word and mode in the clk domain.
`timescale 1ns/1ps
module sod_decoder (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic issue,
  input wire logic [31:0] instrWord,
  input sod_pkg::sod_mode_s mode,
  output sod_pkg::sod_result_s result,
  output sod_pkg::sod_result_s heldResult_r
);
  import sod_pkg::*;

  // Picks one column out of a row of eight table entries. Every table
  // below but the system-coprocessor function set keeps its rows this way, so one helper serves all of those.
  function automatic logic pick(input logic [7:0] rowBits,
                                input logic [2:0] col);
    pick = rowBits[col];
  endfunction

  // Defined entries of the register-function table, one row at a time.
  // Bit n of a row is column n; a clear bit marks a reserved slot.
  // Row 0 holds the shifts with columns 1 and 5 reserved, row 1 the
  // jumps, system call, breakpoints and sync with columns 2 and 3
  // reserved, and row 3 the 32-bit then 64-bit multiplies and divides.
  function automatic logic [7:0] regFnRow(input logic [2:0] row);
    case (row)
      3'h0: regFnRow = 8'hDD;
      3'h1: regFnRow = 8'hF3;
      3'h2: regFnRow = 8'hDF;
      3'h3: regFnRow = 8'hFF;
      3'h4: regFnRow = 8'hFF;
      3'h5: regFnRow = 8'hFC;
      3'h6: regFnRow = 8'h5F;
      3'h7: regFnRow = 8'hDD;
      default: regFnRow = 8'h00;
    endcase
  endfunction

  // Register-function entries that exist only for 64-bit operation. They
  // are legal in kernel mode or with 64-bit addressing switched on.
  function automatic logic [7:0] regFnWideRow(input logic [2:0] row);
    case (row)
      3'h2: regFnWideRow = 8'hD0;
      3'h3: regFnWideRow = 8'hF0;
      3'h5: regFnWideRow = 8'hF0;
      3'h7: regFnWideRow = 8'hDD;
      default: regFnWideRow = 8'h00;
    endcase
  endfunction

  // Register-immediate table indexed by rt: sign branches, immediate
  // traps, linking branches, and a last row that is reserved throughout.
  function automatic logic [7:0] regImmRow(input logic [1:0] row);
    case (row)
      2'h0: regImmRow = 8'h0F;
      2'h1: regImmRow = 8'h5F;
      2'h2: regImmRow = 8'h0F;
      2'h3: regImmRow = 8'h00;
      default: regImmRow = 8'h00;
    endcase
  endfunction

  // Coprocessor rs table: row 0 holds the moves and control transfers,
  // row 1 only the branch class in column 0. Rows 2 and 3 are the
  // coprocessor function space and are decoded on their own path.
  function automatic logic [7:0] copRsRow(input logic [1:0] row);
    case (row)
      2'h0: copRsRow = 8'h77;
      2'h1: copRsRow = 8'h01;
      default: copRsRow = 8'h00;
    endcase
  endfunction

  // Doubleword moves in rs row 0 are 64-bit-only operations.
  localparam logic [7:0] COP_RS_WIDE = 8'h22;

  // Coprocessor branch table indexed by rt: false, true and the likely
  // forms of both in row 0; every other entry is reserved.
  function automatic logic [7:0] copBrRow(input logic [1:0] row);
    case (row)
      2'h0: copBrRow = 8'h0F;
      default: copBrRow = 8'h00;
    endcase
  endfunction

  // Assigned system-coprocessor functions: entry read, indexed and random
  // writes, probe, the two returns and wait. All others act as no-ops.
  function automatic logic sysFnKnown(input logic [5:0] fn);
    case (fn)
      6'h01, 6'h02, 6'h06, 6'h08: sysFnKnown = 1'b1;
      6'h18, 6'h1F, 6'h20: sysFnKnown = 1'b1;
      default: sysFnKnown = 1'b0;
    endcase
  endfunction

  // Multiply-accumulate table: signed and unsigned multiply-add in row 0;
  // the rest of the field is reserved.
  function automatic logic [7:0] macRow(input logic [2:0] row);
    case (row)
      3'h0: macRow = 8'h03;
      default: macRow = 8'h00;
    endcase
  endfunction

  logic [5:0] opcode;
  logic [4:0] rsF;
  logic [4:0] rtF;
  logic [5:0] fnF;
  logic isCop;
  logic [1:0] copNum;
  logic wideOk;
  logic copAllowed;
  logic regFnOk;
  logic regImmOk;
  logic isCopBranch;
  logic copBrOk;
  logic copMoveOk;
  logic macOk;
  sod_result_s res;

  // Split the word into the fields that the secondary tables use. The
  // primary opcode decides which of them matters.
  assign opcode = instrWord[SOD_OP_HI:SOD_OP_LO];
  assign rsF = instrWord[SOD_RS_HI:SOD_RS_LO];
  assign rtF = instrWord[SOD_RT_HI:SOD_RT_LO];
  assign fnF = instrWord[SOD_FN_HI:SOD_FN_LO];

  // The four coprocessor opcodes share their upper bits; the low two
  // bits name the coprocessor and select its usable bit.
  assign copNum = opcode[1:0];
  assign isCop = (opcode[5:2] == SOD_OP_SYSTEM_COPROCESSOR_CLASS[5:2]);
  assign copAllowed = mode.copUsable[copNum];

  // 64-bit-only operations are allowed in kernel mode, or in user and
  // supervisor mode once 64-bit addressing is switched on.
  assign wideOk = (mode.privMode == SOD_MODE_KERNEL) ||
      mode.addr64En;

  // Register-function slot: defined, and wide slots only when permitted.
  assign regFnOk = pick(regFnRow(fnF[5:3]), fnF[2:0]) &&
      (!pick(regFnWideRow(fnF[5:3]), fnF[2:0]) || wideOk);

  // Register-immediate slot, row from rt[4:3] and column from rt[2:0].
  assign regImmOk = pick(regImmRow(rtF[4:3]), rtF[2:0]);

  // The branch class sits at rs row 1 column 0; rt then picks the form.
  assign isCopBranch = (rsF[4:3] == 2'h1) && (rsF[2:0] == 3'h0);
  assign copBrOk = pick(copBrRow(rtF[4:3]), rtF[2:0]);

  // Moves and control transfers in rs row 0; doubleword moves are wide.
  assign copMoveOk = pick(copRsRow(rsF[4:3]), rsF[2:0]) &&
      (!(rsF[4:3] == 2'h0 && pick(COP_RS_WIDE, rsF[2:0])) ||
      wideOk);

  // Multiply-accumulate slot, rows and columns as in the function field.
  assign macOk = pick(macRow(fnF[5:3]), fnF[2:0]);

  // Combine the class decodes into one result. Coprocessor unusable wins
  // over reserved, so software sees the access fault first.
  always_comb begin
    res = '0;
    res.copNum = copNum;
    res.slot = fnF;
    case (opcode)
      SOD_OP_REGFN: begin
        res.opClass = SOD_CLS_REGFN;
        res.valid = regFnOk;
        res.resvExc = !regFnOk;
      end
      SOD_OP_REGISTER_IMMEDIATE_CLASS: begin
        res.opClass = SOD_CLS_REGISTER_IMMEDIATE_CLASS;
        res.slot = {1'b0, rtF};
        res.valid = regImmOk;
        res.resvExc = !regImmOk;
      end
      SOD_OP_MAC: begin
        res.opClass = SOD_CLS_MAC;
        res.valid = macOk;
        res.resvExc = !macOk;
      end
      default: begin
        if (isCop) begin
          res.opClass = SOD_CLS_COPOP;
          res.slot = {1'b0, rsF};
          if (!copAllowed) begin
            res.copUnusableExc = 1'b1;
          end else if (rsF[4]) begin
            // Function space: only the system coprocessor defines it, and
            // its unassigned values run as no-ops rather than trapping.
            if (copNum == 2'h0) begin
              res.opClass = SOD_CLS_SYSCOP;
              res.slot = fnF;
              res.valid = 1'b1;
              res.isNop = !sysFnKnown(fnF);
            end else begin
              res.resvExc = 1'b1;
            end
          end else if (isCopBranch) begin
            // Branch class: rt holds the actual branch form.
            res.opClass = SOD_CLS_COPBR;
            res.slot = {1'b0, rtF};
            res.valid = copBrOk;
            res.resvExc = !copBrOk;
          end else if (copNum == 2'h3) begin
            res.resvExc = 1'b1;
          end else begin
            res.valid = copMoveOk;
            res.resvExc = !copMoveOk;
          end
        end
      end
    endcase
  end

  // The live decode goes straight out for the stage that needs it now.
  assign result = res;

  // Registered copy of the result for the issued instruction.
  sod_result_reg u_hold (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(issue),
    .resultNxt(res),
    .result_r(heldResult_r)
  );
endmodule

// ### sod_decoder_props.sv
// Checker for the secondary opcode decoder result and its holding copy.
// Assumes it is bound to sod_decoder and sees only that module's ports.
`timescale 1ns/1ps
module sod_decoder_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic issue,
  input wire logic [31:0] instrWord,
  input sod_pkg::sod_mode_s mode,
  input sod_pkg::sod_result_s result,
  input sod_pkg::sod_result_s heldResult_r
);
  import sod_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Fields of the word under decode.
  wire logic [5:0] opF = instrWord[31:26];
  wire logic [4:0] rsF = instrWord[25:21];
  wire logic [4:0] rtF = instrWord[20:16];
  wire logic [5:0] fnF = instrWord[5:0];
  sequence s_issue; issue; endsequence
  sequence s_take; heldResult_r == $past(result); endsequence
  property p_take; s_issue |=> s_take; endproperty
  property p_stand; !issue |=> $stable(heldResult_r); endproperty
  property p_shift; opF == 6'h00 && fnF inside {6'h01, 6'h05}
    |-> result.resvExc; endproperty
  property p_rimm; opF == 6'h01 && rtF[4:3] == 2'h3 |-> result.resvExc;
  endproperty
  property p_nop; opF == 6'h10 && rsF[4] && mode.copUsable[0]
    && fnF == 6'h03 |-> result.isNop && !result.resvExc; endproperty
  property p_unus; opF == 6'h11 && !mode.copUsable[1]
    |-> result.copUnusableExc; endproperty
  property p_cop3; opF == 6'h13 && mode.copUsable[3] && rsF != 5'h08
    |-> result.resvExc; endproperty
  property p_mac; opF == 6'h1C && fnF > 6'h01 |-> result.resvExc;
  endproperty
  property p_wide; opF == 6'h00 && fnF == 6'h1C && mode.privMode != 2'h0
    && !mode.addr64En |-> result.resvExc; endproperty
  property p_slot; opF == 6'h00 |-> result.opClass == SOD_CLS_REGFN
    && result.slot == fnF; endproperty
  property p_row1; opF == 6'h00 && fnF inside {6'h0A, 6'h0B}
    |-> result.resvExc; endproperty
  property p_cpbr; opF == 6'h11 && mode.copUsable[1] && rsF == 5'h08
    && rtF > 5'h03 |-> result.resvExc; endproperty
  a_take: assert property (p_take) else $error("held copy wrong");
  a_stand: assert property (p_stand) else $error("held moved");
  a_shift: assert property (p_shift) else $error("shift slot");
  a_rimm: assert property (p_rimm) else $error("rt row 3");
  a_nop: assert property (p_nop) else $error("system no-op");
  a_unus: assert property (p_unus) else $error("unusable");
  a_cop3: assert property (p_cop3) else $error("cop3 rs");
  a_mac: assert property (p_mac) else $error("mac slot");
  a_wide: assert property (p_wide) else $error("wide op");
  a_slot: assert property (p_slot) else $error("fn slot");
  a_row1: assert property (p_row1) else $error("row 1 slot");
  a_cpbr: assert property (p_cpbr) else $error("cop branch");
endmodule
bind sod_decoder sod_decoder_props chk (.clk(clk), .sys_rst(sys_rst),
  .issue(issue), .instrWord(instrWord), .mode(mode), .result(result),
  .heldResult_r(heldResult_r));

// ### sod_exc_model.sv
// Exception unit model: counts exception requests in the held result.
// Assumes heldResult_r is loaded at the edge that samples issue high.
`timescale 1ns/1ps
module sod_exc_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic issue,
  input sod_pkg::sod_result_s heldResult_r,
  output int excCount
);
  import sod_pkg::*;
  logic taken_r;
  // Takes one request per issued word, a cycle after capture.
  always_ff @(posedge clk) begin
    taken_r <= issue && !sys_rst;
    if (sys_rst) begin
      excCount <= 0;
    end else if (taken_r && (heldResult_r.resvExc
        || heldResult_r.copUnusableExc)) begin
      excCount <= excCount + 1;
    end
  end
endmodule

// ### secondary_opcode_decoder_tb_top.sv
// Testbench for the secondary opcode decoder with an exception model.
// Assumes a 50 MHz clock and synchronous active-high reset.
`timescale 1ns/1ps
module secondary_opcode_decoder_tb_top;
  import sod_pkg::*;
  logic clk = 0, sys_rst = 1, issue = 0;
  logic [31:0] instrWord = '0;
  sod_mode_s mode = '0;
  sod_result_s result, heldResult_r;
  int excCount, nErrors = 0, checksDone = 0, cycles = 0, expExc = 0;
  logic [7:0] lfsr = 8'h36;
  logic [6:0] notes[$];
  logic [6:0] note;
  logic [45:0] vec[15];
  sod_decoder dut (.clk(clk), .sys_rst(sys_rst), .issue(issue),
    .instrWord(instrWord), .mode(mode), .result(result),
    .heldResult_r(heldResult_r));
  sod_exc_model exu (.clk(clk), .sys_rst(sys_rst), .issue(issue),
    .heldResult_r(heldResult_r), .excCount(excCount));
  function automatic logic [7:0] nextLfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Gathers class, valid and exception flags in the order of the notes.
  function automatic logic [6:0] flagsOf(input sod_result_s r);
    return {r.opClass, r.valid, r.resvExc, r.isNop, r.copUnusableExc};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    checksDone++;
    if (seen !== exp) begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task endSim;
    if (nErrors == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Clock and a cycle ceiling against hangs.
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      nErrors++;
      endSim();
    end
  end
  // Compares the live and the captured result with the oldest note.
  always @(posedge clk) begin
    if (issue === 1'b1) begin
      note = notes.pop_front();
      check("result", 32'(flagsOf(result)), 32'(note));
      #2;
      check("held", 32'(flagsOf(heldResult_r)), 32'(note));
    end
  end
  // Words, modes, classes and expected {valid, reserved, no-op, unusable}.
  initial begin
    vec[0] = {32'h0000_0001, 7'h4F, SOD_CLS_REGFN, 4'h4};
    vec[1] = {32'h0000_0008, 7'h4F, SOD_CLS_REGFN, 4'h8};
    vec[2] = {32'h0000_001C, 7'h4F, SOD_CLS_REGFN, 4'h4};
    vec[3] = {32'h0000_001C, 7'h0F, SOD_CLS_REGFN, 4'h8};
    vec[4] = {32'h0418_0000, 7'h4F, SOD_CLS_REGISTER_IMMEDIATE_CLASS, 4'h4};
    vec[5] = {32'h0401_0000, 7'h4F, SOD_CLS_REGISTER_IMMEDIATE_CLASS, 4'h8};
    vec[6] = {32'h4400_0000, 7'h4D, SOD_CLS_COPOP, 4'h1};
    vec[7] = {32'h4504_0000, 7'h4F, SOD_CLS_COPBR, 4'h4};
    vec[8] = {32'h4C00_0000, 7'h4F, SOD_CLS_COPOP, 4'h4};
    vec[9] = {32'h4200_0003, 7'h0F, SOD_CLS_SYSCOP, 4'hA};
    vec[10] = {32'h4200_0018, 7'h0F, SOD_CLS_SYSCOP, 4'h8};
    vec[11] = {32'h7000_0002, 7'h4F, SOD_CLS_MAC, 4'h4};
    vec[12] = {32'h0800_0000, 7'h4F, SOD_CLS_NONE, 4'h0};
    vec[13] = {32'h0000_000A, 7'h0F, SOD_CLS_REGFN, 4'h4};
    vec[14] = {32'h4460_0000, 7'h4F, SOD_CLS_COPOP, 4'h4};
    repeat (4) @(posedge clk);
    #1 sys_rst = 0;
    for (int i = 0; i < 15; i++) begin
      lfsr = nextLfsr(lfsr);
      instrWord = vec[i][45:14] | {16'h0000, lfsr, lfsr[1:0], 6'h00};
      mode = vec[i][13:7];
      issue = 1;
      notes.push_back(vec[i][6:0]);
      if (vec[i][2] | vec[i][0]) expExc++;
      @(posedge clk);
      #1;
    end
    issue = 0;
    repeat (3) @(posedge clk);
    check("excCount", 32'(excCount), 32'(expExc));
    endSim();
  end
endmodule
